// >>> hdl/lls_pkg.sv
// Shared constants and carrier types for the line sync glue.
// Assumes one core clock domain; all pins arrive asynchronously.
`default_nettype none
package lls_pkg;
	localparam int          CNT_W      = 14;      // Shift register and down-counter width
	localparam logic [13:0] CNT_RST    = 14'h0000; // Counter value after reset
	localparam logic [13:0] SHIFT_RST  = 14'h0000; // Shift register value after reset
	localparam logic        VIDEO_RST  = 1'b1;     // Laser video level after reset
	localparam int          SYNC_DEPTH = 2;        // Flip-flops per input synchroniser

	// Serial load link from the controller
	typedef struct packed {
		logic sel_n;  // Chip select, active low
		logic clk;    // Serial clock
		logic dat;    // Serial data bit
	} lls_ser_t;

	// Shared converter / smart-card signals from the controller
	typedef struct packed {
		logic conv_sel_n; // 0 converter in use, 1 smart card in use
		logic clk;        // Shared serial clock
		logic dat_o;      // Controller drive on shared data pin
		logic dat_oe;     // Controller drive enable
	} lls_shr_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00, // Laser forced on, waiting for enable
		ST_ARMED = 2'b01, // Loaded, waiting for sync rise
		ST_COUNT = 2'b11, // Counting down, laser off
		ST_DONE  = 2'b10  // Count reached zero, laser on
	} lls_state_t;
endpackage : lls_pkg
`default_nettype wire

// >>> hdl/lls_glue.sv
// Line sync glue: serial-loaded delay, line-sync down-counter, converter mux.
// Assumes pin inputs are asynchronous to core_clk; serial link, enable and line sync are synchronised here.
// How it works
// RQ1 - Fourteen bit shift register loaded serially
// RQ2 - Sync fall copies shift register into counter
// RQ3 - Sync rise after load starts decrementing
// RQ4 - Video low counting, high at zero
// RQ5 - Video high after reset release
// RQ6 - Controller loads delay before setting enable
// RQ7 - Laser on until first sync fall
// RQ8 - Reload and restart every line automatically
// RQ9 - Controller select low converter, high card
// RQ10 - Pass to converter only in converter mode
// RQ11 - One shared pin, never both driving
// RQ12 - Video one means laser lit
// RQ13 - Counter decrements once per core clock
// RQ14 - Capture on serial clock rise, MSB first
`default_nettype none
module lls_glue #(
	parameter int W = 14 // Delay width
) (
	input  wire logic           core_clk,        // Core clock, 100 MHz
	input  wire logic           nrst,            // Async reset, active low
	input  wire lls_pkg::lls_ser_t ser_in,       // Serial load link
	input  wire logic           laser_print_enable, // Print enable from controller
	input  wire logic           line_sync,       // Beam detect line sync pin
	output logic                laser_video_out, // 1 laser on
	input  wire lls_pkg::lls_shr_t shr_in,       // Shared converter bus
	input  wire logic           conv_dout,       // Converter result bit
	output logic                conv_sel_n,      // Converter select, active low
	output logic                conv_clk,        // Converter clock
	output logic                serial_bit_in,   // Converter command bit
	output logic                shr_dat_i,       // Level read back on shared pin
	output logic                shr_dat_oe       // Device drives shared pin
);
	// Two-stage synchronisers for the serial link, enable and line sync pins
	// Reset to the idle pin levels so no false edge or enable follows reset
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [4:0] raw;
	assign raw = {ser_in.sel_n, ser_in.clk, ser_in.dat, laser_print_enable, line_sync};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= 5'h11;
			s2_r <= 5'h11;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	logic sel_n_s, sclk_s, sdat_s, en_s, sync_s;
	assign {sel_n_s, sclk_s, sdat_s, en_s, sync_s} = s2_r;

	// Edge history registers read only the second stage
	logic sclk_d_r;
	logic sync_d_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d_r <= 1'b0;
			sync_d_r <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			sync_d_r <= sync_s;
		end
	end
	logic sclk_rise, sync_fall, sync_rise;
	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sync_fall = ~sync_s & sync_d_r;
	assign sync_rise = sync_s & ~sync_d_r;

	// RQ1 RQ14 serial MSB-first capture
	logic [W-1:0] shift_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shift_r <= W'(lls_pkg::SHIFT_RST);
		end else if (!sel_n_s && sclk_rise) begin
			shift_r <= {shift_r[W-2:0], sdat_s};
		end
	end

	// Line state machine: RQ6 assumes delay loaded before enable
	lls_pkg::lls_state_t st_r;
	lls_pkg::lls_state_t st_nxt;
	logic [W-1:0] cnt_r;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			lls_pkg::ST_IDLE: begin
				// RQ7 laser held until first fall
				if (en_s && sync_fall) st_nxt = lls_pkg::ST_ARMED;
			end
			lls_pkg::ST_ARMED: begin
				// RQ3 rise starts the count
				if (sync_rise) st_nxt = (cnt_r == '0) ? lls_pkg::ST_DONE : lls_pkg::ST_COUNT;
			end
			lls_pkg::ST_COUNT: begin
				// A fall wins over the last step, else that line would be lost
				if (sync_fall) st_nxt = lls_pkg::ST_ARMED;
				else if (cnt_r == W'(1)) st_nxt = lls_pkg::ST_DONE;
			end
			lls_pkg::ST_DONE: begin
				// RQ8 automatic reload each line
				if (sync_fall) st_nxt = lls_pkg::ST_ARMED;
			end
			default: st_nxt = lls_pkg::ST_IDLE;
		endcase
		if (!en_s) st_nxt = lls_pkg::ST_IDLE;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) st_r <= lls_pkg::ST_IDLE;
		else st_r <= st_nxt;
	end

	// RQ2 RQ13 load on fall, decrement per clock
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= W'(lls_pkg::CNT_RST);
		end else if (sync_fall && en_s) begin
			cnt_r <= shift_r;
		end else if (st_r == lls_pkg::ST_COUNT && cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	// Registered from the next state so the laser pin never glitches
	// RQ4 RQ5 RQ12 video level, one is laser lit
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) laser_video_out <= lls_pkg::VIDEO_RST;
		else laser_video_out <= (st_nxt != lls_pkg::ST_COUNT);
	end

	// RQ9 RQ10 converter only sees traffic in converter mode
	// Signals are pure gating; the controller owns their timing
	always_comb begin
		conv_sel_n    = shr_in.conv_sel_n;
		conv_clk      = shr_in.clk & ~shr_in.conv_sel_n;
		serial_bit_in = shr_in.dat_o & ~shr_in.conv_sel_n;
	end

	// RQ11 device returns data only while controller is not driving
	assign shr_dat_oe = ~shr_in.conv_sel_n & ~shr_in.dat_oe;
	assign shr_dat_i  = shr_dat_oe ? conv_dout : shr_in.dat_o;

	// RQ5 video is high right after reset
	chk_video_reset: assert property (@(posedge core_clk) $rose(nrst) |-> laser_video_out) // RQ5
		else $error("video not high after reset");
	// RQ4 video low while counting
	chk_video_count: assert property (@(posedge core_clk) disable iff (!nrst) // RQ4
		st_r == lls_pkg::ST_COUNT && $past(st_r) == lls_pkg::ST_COUNT |-> !laser_video_out)
		else $error("video high while counting");
	// RQ7 idle keeps laser on
	chk_idle_on: assert property (@(posedge core_clk) disable iff (!nrst) // RQ7
		st_r == lls_pkg::ST_IDLE |=> laser_video_out)
		else $error("laser off before first sync fall");
	// RQ2 counter loaded on fall
	chk_load_fall: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
		sync_fall && en_s |=> cnt_r == $past(shift_r))
		else $error("counter not loaded on sync fall");
	// RQ3 armed holds until rise
	chk_armed_hold: assert property (@(posedge core_clk) disable iff (!nrst) // RQ3
		st_r == lls_pkg::ST_ARMED && !sync_rise && en_s |=> $stable(cnt_r))
		else $error("counter moved before sync rise");
	// RQ13 one step per clock
	chk_dec_step: assert property (@(posedge core_clk) disable iff (!nrst) // RQ13
		st_r == lls_pkg::ST_COUNT && cnt_r != '0 && !sync_fall |=> cnt_r == $past(cnt_r) - W'(1))
		else $error("counter did not step by one");
	// RQ8 each fall rearms
	chk_rearm: assert property (@(posedge core_clk) disable iff (!nrst) // RQ8
		st_r == lls_pkg::ST_DONE && sync_fall && en_s |=> st_r == lls_pkg::ST_ARMED)
		else $error("no rearm at end of line");
	// RQ14 shift captures data bit
	chk_shift_in: assert property (@(posedge core_clk) disable iff (!nrst) // RQ14
		!sel_n_s && sclk_rise |=> shift_r[0] == $past(sdat_s))
		else $error("serial bit not captured");
	// RQ10 converter clock quiet in card mode
	chk_conv_gate: assert property (@(posedge core_clk) disable iff (!nrst) // RQ10
		shr_in.conv_sel_n |-> !conv_clk && !shr_dat_oe)
		else $error("converter active in card mode");
	// RQ11 no double drive
	chk_no_fight: assert property (@(posedge core_clk) disable iff (!nrst) // RQ11
		!(shr_dat_oe && shr_in.dat_oe))
		else $error("shared pin driven twice");
	// RQ4 laser lit once count is done
	chk_video_done: assert property (@(posedge core_clk) disable iff (!nrst) // RQ4
		st_r == lls_pkg::ST_DONE |-> laser_video_out)
		else $error("laser dark after count end");
	// RQ12 laser lit while beam waits on sensor
	chk_armed_lit: assert property (@(posedge core_clk) disable iff (!nrst) // RQ12
		st_r == lls_pkg::ST_ARMED |-> laser_video_out)
		else $error("laser dark while armed");
	// RQ12 dark only while counting
	chk_dark_count: assert property (@(posedge core_clk) disable iff (!nrst) // RQ12
		!laser_video_out |-> st_r == lls_pkg::ST_COUNT)
		else $error("laser dark outside count");
	// RQ3 rise starts a nonzero count
	chk_rise_start: assert property (@(posedge core_clk) disable iff (!nrst) // RQ3
		st_r == lls_pkg::ST_ARMED && sync_rise && en_s && cnt_r != '0
		|=> st_r == lls_pkg::ST_COUNT && !laser_video_out)
		else $error("count not started on sync rise");
	// RQ4 zero load gives no dark time
	chk_armed_zero: assert property (@(posedge core_clk) disable iff (!nrst) // RQ4
		st_r == lls_pkg::ST_ARMED && sync_rise && en_s && cnt_r == '0 |=> st_r == lls_pkg::ST_DONE)
		else $error("zero load did not finish at once");
	// RQ4 count end relights laser
	chk_count_stop: assert property (@(posedge core_clk) disable iff (!nrst) // RQ4
		st_r == lls_pkg::ST_COUNT && cnt_r == W'(1) && en_s && !sync_fall
		|=> st_r == lls_pkg::ST_DONE && laser_video_out)
		else $error("laser not relit at count end");
	// RQ7 enable low forces laser on
	chk_enable_low: assert property (@(posedge core_clk) disable iff (!nrst) // RQ7
		!en_s |=> st_r == lls_pkg::ST_IDLE && laser_video_out)
		else $error("laser not held on without enable");
	// RQ14 shift ignores clock without select
	chk_shift_hold: assert property (@(posedge core_clk) disable iff (!nrst) // RQ14
		(sel_n_s || !sclk_rise) |=> $stable(shift_r))
		else $error("shift register moved without select");
	// RQ10 converter sees traffic in its mode
	chk_conv_pass: assert property (@(posedge core_clk) disable iff (!nrst) // RQ10
		!shr_in.conv_sel_n |-> conv_clk == shr_in.clk && serial_bit_in == shr_in.dat_o)
		else $error("converter traffic not passed");
endmodule : lls_glue
`default_nettype wire

// >>> verif/lls_lsu_model.sv
// Laser scan unit model: the beam sensor only pulses when the laser is lit.
// Assumes the bench raises sweep once per line, well apart in time.
`default_nettype none
module lls_lsu_model (
	input  wire logic sweep,     // Beam starts a sweep
	input  wire logic lit,       // Laser video level
	output logic      line_sync  // Sensor, low while beam on it
);
	timeunit 1ns;
	timeprecision 1ns;
	// sensor needs light
	// Dark laser gives no pulse, as on the real sensor
	initial begin
		line_sync = 1'b1;
		forever begin
			@(posedge sweep);
			if (lit === 1'b1) begin
				line_sync = 1'b0;
				#200;
				line_sync = 1'b1;
			end
		end
	end
endmodule : lls_lsu_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the line sync glue.
// Assumes the scan unit model answers sweeps; converter side driven here.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic              core_clk, nrst, en, sweep, sync, video, dout;
	logic              c_sel_n, c_clk, c_bit, d_i, d_oe;
	lls_pkg::lls_ser_t ser;
	lls_pkg::lls_shr_t shr;
	int                bad_count, total_checks;
	lls_glue lls_glue_i (.core_clk(core_clk), .nrst(nrst), .ser_in(ser), .laser_print_enable(en),
		.line_sync(sync), .laser_video_out(video), .shr_in(shr), .conv_dout(dout), .conv_sel_n(c_sel_n),
		.conv_clk(c_clk), .serial_bit_in(c_bit), .shr_dat_i(d_i), .shr_dat_oe(d_oe));
	lls_lsu_model lls_lsu_model_i (.sweep(sweep), .lit(video), .line_sync(sync));
	// Core clock, 100 MHz
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	// Serial link at 125 ns per bit, MSB first; sel_n high means edges are ignored
	// Link edges start 2 ns after a core falling edge and none lands on a sampling edge
	task automatic ser_load(logic [13:0] v, logic sel_n);
		@(negedge core_clk) ser.sel_n = sel_n;
		#2;
		for (int i = 13; i >= 0; i--) begin
			ser.dat = v[i];
			#62 ser.clk = 1'b1;
			#63 ser.clk = 1'b0;
		end
		@(negedge core_clk) ser.sel_n = 1'b1;
		ser.dat = 1'b0;
	endtask : ser_load
	// One beam sweep; counts cycles with the laser dark
	task automatic line(int n);
		int lo;
		lo = 0;
		@(negedge core_clk) sweep = 1'b1;
		@(negedge core_clk) sweep = 1'b0;
		for (int k = 0; k < 100; k++) begin
			@(negedge core_clk);
			if (video === 1'b0) lo++;
		end
		check("dark cycles", 14'(lo), 14'(n));
		check("lit after count", 14'(video), 14'h0001);
	endtask : line
	// Converter / card steering, pure gating
	task automatic shared;
		@(negedge core_clk);
		shr = '{1'b0, 1'b1, 1'b1, 1'b0};
		dout = 1'b1;
		#1 check("conv mode", 14'({c_sel_n, c_clk, c_bit, d_oe, d_i}), 14'h000F);
		@(negedge core_clk);
		shr.dat_oe = 1'b1;
		shr.dat_o = 1'b0;
		#1 check("ctl drives", 14'({d_oe, d_i}), 14'h0000);
		@(negedge core_clk);
		shr = '{1'b1, 1'b1, 1'b1, 1'b0};
		#1 check("card mode", 14'({c_sel_n, c_clk, c_bit, d_oe, d_i}), 14'h0011);
		@(negedge core_clk);
	endtask : shared
	initial begin
		nrst = 1'b0;
		en = 1'b0;
		sweep = 1'b0;
		dout = 1'b0;
		ser = '{1'b1, 1'b0, 1'b0};
		shr = '{1'b1, 1'b0, 1'b0, 1'b0};
		bad_count = 0;
		total_checks = 0;
		repeat (5) @(negedge core_clk);
		nrst = 1'b1;
		repeat (4) @(negedge core_clk);
		check("video after reset", 14'(video), 14'h0001);
		line(0);
		ser_load(14'h0014, 1'b0);
		ser_load(14'h3FFF, 1'b1);
		en = 1'b1;
		repeat (50) @(negedge core_clk);
		check("lit before sync", 14'(video), 14'h0001);
		line(20);
		line(20);
		ser_load(14'h0000, 1'b0);
		line(0);
		ser_load(14'h0005, 1'b0);
		line(5);
		en = 1'b0;
		line(0);
		shared();
		summarize();
	end
endmodule : testbench
`default_nettype wire
